/* prbs_checker_status_counters.sv */
// Added by the designer: the APB register port.
`timescale 1ns/1ns
// How it works
// - Upper packet count half readable read-only
// - Status write bit0 snapshots all counters
// - Status write bit1 snapshots, clears counters, flags
// - Single mode: packet counter stops at full
// - Errored-bit count eight bits, saturates single mode
// - Packet overflow flag sticks until lock-clear
// - Byte overflow flag sticks until lock-clear
// - Lock bit follows checker synchronisation
// - Busy bit follows packet generator activity
// - Done bit set after all packets sent
// - Sticky sync bit, software writes zero clears
// - Error overflow count saturates, snapshot captured
// - Error overflow count idle in single mode
// - Lower errored-packet count readable, snapshot frozen
// - Continuous wraps with pulse, single halts counting
// - Lower packet count half readable, snapshot frozen
module prbs_checker_status_counters
  import prbs_stat_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rx_packet,
  input wire logic i_rx_packet_errored,
  input wire logic i_rx_byte,
  input wire logic i_bit_error,
  input wire logic i_checker_locked,
  input wire logic i_gen_busy,
  input wire logic i_gen_done,
  output logic o_irq
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
    logic continuous;
    logic [PKT_W-1:0] snap_pkt;
    logic [BYTE_W-1:0] snap_byte;
    logic [ERR_W-1:0] snap_err;
    logic [ERR_OV_W-1:0] snap_err_ov;
    logic [ERR_PKT_W-1:0] snap_err_pkt;
    logic [ERR_OV_W-1:0] err_ov;
    logic packet_counter_overflowed;
    logic byte_counter_overflowed;
    logic gen_done;
    logic sync_seen;
    logic lock_prev;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } stat_state_t;

  stat_state_t state;
  stat_state_t next_state;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
    return addr[ADDR_W-1:IDX_LSB] == idx;
  endfunction : reg_hit

  logic access;
  logic wr_status;
  logic do_snapshot;
  logic do_clear;
  logic halted;
  logic pkt_ov_evt;
  logic byte_ov_evt;
  logic lock_rise;
  logic [IRQ_W-1:0] irq_evt;
  logic [PKT_W-1:0] pkt_count;
  logic [BYTE_W-1:0] byte_count;
  logic [ERR_W-1:0] err_count;
  logic [ERR_PKT_W-1:0] err_pkt_count;
  logic pkt_max;
  logic byte_max;
  logic err_max;
  logic err_pkt_max;
  logic pkt_wrap;
  logic byte_wrap;
  logic err_wrap;

  assign access = i_psel & i_penable & state.pready;
  assign wr_status = access & i_pwrite & reg_hit(i_paddr, IDX_STATUS);
  assign do_snapshot = wr_status & (i_pwdata[BIT_SNAPSHOT] | i_pwdata[BIT_SNAP_CLEAR]);
  assign do_clear = wr_status & i_pwdata[BIT_SNAP_CLEAR];
  // Single mode: any live counter at full scale stops all counting
  assign halted = !state.continuous & (pkt_max | byte_max | err_max | err_pkt_max);
  // Full scale ends with a lock-and-clear, so it raises no flag in that cycle
  assign pkt_ov_evt = pkt_wrap | (!state.continuous & pkt_max & ~do_clear);
  assign byte_ov_evt = byte_wrap | (!state.continuous & byte_max & ~do_clear);
  assign lock_rise = i_checker_locked & ~state.lock_prev;

  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_PKT_OV] = pkt_ov_evt & ~state.packet_counter_overflowed;
    irq_evt[IRQ_BYTE_OV] = byte_ov_evt & ~state.byte_counter_overflowed;
    irq_evt[IRQ_GEN_DONE] = i_gen_done;
    irq_evt[IRQ_SYNC] = lock_rise;
  end

  sat_counter #(.WIDTH(PKT_W)) u_pkt_counter (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_inc(i_rx_packet & ~halted),
    .i_clear(do_clear),
    .i_continuous(state.continuous),
    .o_count(pkt_count),
    .o_at_max(pkt_max),
    .o_wrap(pkt_wrap)
  );

  sat_counter #(.WIDTH(BYTE_W)) u_byte_counter (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_inc(i_rx_byte & ~halted),
    .i_clear(do_clear),
    .i_continuous(state.continuous),
    .o_count(byte_count),
    .o_at_max(byte_max),
    .o_wrap(byte_wrap)
  );

  sat_counter #(.WIDTH(ERR_W)) u_err_counter (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_inc(i_bit_error & ~halted),
    .i_clear(do_clear),
    .i_continuous(state.continuous),
    .o_count(err_count),
    .o_at_max(err_max),
    .o_wrap(err_wrap)
  );

  sat_counter #(.WIDTH(ERR_PKT_W)) u_err_pkt_counter (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_inc(i_rx_packet_errored & ~halted),
    .i_clear(do_clear),
    .i_continuous(state.continuous),
    .o_count(err_pkt_count),
    .o_at_max(err_pkt_max),
    .o_wrap()
  );

  always_comb begin
    next_state = state;
    next_state.lock_prev = i_checker_locked;
    // One wait state, then the access completes
    next_state.pready = i_psel & i_penable & ~state.pready;
    next_state.pslverr = 1'b0;
    if (i_psel && i_penable && !state.pready) begin
      next_state.prdata = '0;
      unique case (i_paddr[ADDR_W-1:IDX_LSB])
        IDX_BYTE_COUNT: next_state.prdata[BYTE_W-1:0] = state.snap_byte;
        IDX_PKT_LOW: next_state.prdata[REG_W-1:0] = state.snap_pkt[REG_W-1:0];
        IDX_PKT_HIGH: next_state.prdata[REG_W-1:0] = state.snap_pkt[PKT_W-1:REG_W];
        IDX_STATUS: begin
          next_state.prdata[ERR_W-1:0] = state.snap_err;
          next_state.prdata[BIT_LOCK] = i_checker_locked;
          next_state.prdata[BIT_BYTE_OV] = state.byte_counter_overflowed;
          next_state.prdata[BIT_PKT_OV] = state.packet_counter_overflowed;
          next_state.prdata[BIT_GEN_BUSY] = i_gen_busy;
          next_state.prdata[BIT_GEN_DONE] = state.gen_done;
          next_state.prdata[BIT_SYNC_SEEN] = state.sync_seen;
        end
        IDX_ERR_OV: next_state.prdata[ERR_OV_W-1:0] = state.snap_err_ov;
        IDX_ERR_PKT_LOW: next_state.prdata[REG_W-1:0] = state.snap_err_pkt[REG_W-1:0];
        IDX_CONTROL: next_state.prdata[BIT_CONTINUOUS] = state.continuous;
        IDX_IRQ_STATUS: next_state.prdata[IRQ_W-1:0] = state.irq_status;
        IDX_IRQ_MASK: next_state.prdata[IRQ_W-1:0] = state.irq_mask;
        default: next_state.pslverr = 1'b1;
      endcase
    end
    // Frozen copies change only on a snapshot command
    if (do_snapshot) begin
      next_state.snap_pkt = pkt_count;
      next_state.snap_byte = byte_count;
      next_state.snap_err = err_count;
      next_state.snap_err_ov = state.err_ov;
      next_state.snap_err_pkt = err_pkt_count;
    end
    // Overflow count: saturating, active only in continuous mode
    if (do_clear) begin
      next_state.err_ov = '0;
    end else if (state.continuous && err_wrap && !(&state.err_ov)) begin
      next_state.err_ov = ERR_OV_W'(state.err_ov + 1'b1);
    end
    // Overflow flags: sticky until a lock-and-clear
    next_state.packet_counter_overflowed = (state.packet_counter_overflowed & ~do_clear)
      | pkt_ov_evt;
    next_state.byte_counter_overflowed = (state.byte_counter_overflowed & ~do_clear)
      | byte_ov_evt;
    // Done until the generator starts another run
    next_state.gen_done = (state.gen_done & ~i_gen_busy) | i_gen_done;
    next_state.sync_seen = (state.sync_seen & ~(wr_status & ~i_pwdata[BIT_SYNC_SEEN]))
      | lock_rise;
    if (access && i_pwrite && reg_hit(i_paddr, IDX_CONTROL)) begin
      next_state.continuous = i_pwdata[BIT_CONTINUOUS];
    end
    if (access && i_pwrite && reg_hit(i_paddr, IDX_IRQ_MASK)) begin
      next_state.irq_mask = i_pwdata[IRQ_W-1:0];
    end
    if (access && i_pwrite && reg_hit(i_paddr, IDX_IRQ_STATUS)) begin
      next_state.irq_status = state.irq_status & ~i_pwdata[IRQ_W-1:0];
    end
    next_state.irq_status = next_state.irq_status | irq_evt;
    next_state.irq = |(state.irq_status & state.irq_mask);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state <= '0;
      state.continuous <= RESET_CONTINUOUS;
    end else begin
      state <= next_state;
    end
  end

  assign o_prdata = state.prdata;
  assign o_pready = state.pready;
  assign o_pslverr = state.pslverr;
  assign o_irq = state.irq;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  pkt_high_read_a: assert property (
    (i_psel && i_penable && !o_pready && !i_pwrite && reg_hit(i_paddr, IDX_PKT_HIGH))
    |=> o_pready && o_prdata == {16'h0000, state.snap_pkt[PKT_W-1:REG_W]})
    else $error("Upper packet half read wrong");

  snap_capture_a: assert property (
    do_snapshot |=> state.snap_pkt == $past(pkt_count) && state.snap_err == $past(err_count))
    else $error("Snapshot did not capture counters");

  lock_clear_a: assert property (
    do_clear |=> pkt_count == '0 && byte_count == '0 && err_count == '0)
    else $error("Lock and clear left counters nonzero");

  pkt_sat_a: assert property (
    (!state.continuous && pkt_max && !do_clear) |=> pkt_max)
    else $error("Packet counter left full scale in single mode");

  err_sat_a: assert property (
    (!state.continuous && err_max && !do_clear) |=> err_max && state.err_ov == $past(state.err_ov))
    else $error("Errored-bit count moved past full scale");

  pkt_ov_hold_a: assert property (
    (state.packet_counter_overflowed && !do_clear) |=> state.packet_counter_overflowed)
    else $error("Packet overflow flag dropped");

  byte_ov_set_a: assert property (
    byte_wrap |=> state.byte_counter_overflowed && byte_count == '0)
    else $error("Byte overflow not flagged");

  lock_read_a: assert property (
    (i_psel && i_penable && !o_pready && !i_pwrite && reg_hit(i_paddr, IDX_STATUS))
    |=> o_prdata[BIT_LOCK] == $past(i_checker_locked)
        && o_prdata[BIT_GEN_BUSY] == $past(i_gen_busy))
    else $error("Lock or busy bit read wrong");

  gen_done_a: assert property (
    i_gen_done |=> state.gen_done ##1 (state.gen_done || $past(i_gen_busy)))
    else $error("Done bit not set");

  sync_sticky_a: assert property (
    $rose(i_checker_locked) |=> state.sync_seen)
    else $error("Sticky sync bit not set");

  err_ov_idle_a: assert property (
    (!state.continuous && !do_clear) |=> state.err_ov == $past(state.err_ov))
    else $error("Overflow count moved in single mode");

  snap_hold_a: assert property (
    !do_snapshot |=> $stable(state.snap_pkt) && $stable(state.snap_err_pkt))
    else $error("Frozen value changed without snapshot");

  wrap_restart_a: assert property (
    (state.continuous && pkt_wrap) |=> pkt_count == '0 && state.packet_counter_overflowed)
    else $error("Continuous wrap did not restart");

  pkt_low_read_a: assert property (
    (i_psel && i_penable && !o_pready && !i_pwrite && reg_hit(i_paddr, IDX_PKT_LOW))
    |=> o_pready && o_prdata == {{(DATA_W-REG_W){1'b0}}, state.snap_pkt[REG_W-1:0]})
    else $error("Lower packet half read wrong");

  err_pkt_read_a: assert property (
    (i_psel && i_penable && !o_pready && !i_pwrite && reg_hit(i_paddr, IDX_ERR_PKT_LOW))
    |=> o_pready && o_prdata == {{(DATA_W-REG_W){1'b0}}, state.snap_err_pkt[REG_W-1:0]})
    else $error("Errored packet count read wrong");

  err_ov_step_a: assert property (
    (state.continuous && err_wrap && !(&state.err_ov) && !do_clear)
    |=> state.err_ov == ERR_OV_W'($past(state.err_ov) + 1'b1))
    else $error("Overflow count did not step on wrap");

  err_ov_sat_a: assert property (
    (&state.err_ov && !do_clear) |=> &state.err_ov)
    else $error("Overflow count left full scale");

  halt_single_a: assert property (
    (halted && !do_clear) |=> $stable(pkt_count) && $stable(byte_count)
        && $stable(err_count) && $stable(err_pkt_count))
    else $error("Counting went on in single mode at full scale");

  byte_sat_a: assert property (
    (!state.continuous && byte_max && !do_clear) |=> state.byte_counter_overflowed)
    else $error("Byte overflow not flagged at full scale");

  byte_ov_hold_a: assert property (
    (state.byte_counter_overflowed && !do_clear) |=> state.byte_counter_overflowed)
    else $error("Byte overflow flag dropped");

  ov_clear_a: assert property (
    do_clear |=> !state.packet_counter_overflowed && !state.byte_counter_overflowed
        && state.err_ov == '0)
    else $error("Lock and clear left flags set");

  sync_clear_a: assert property (
    (wr_status && !i_pwdata[BIT_SYNC_SEEN] && !lock_rise) |=> !state.sync_seen)
    else $error("Sticky sync bit not cleared");

  sync_hold_a: assert property (
    (state.sync_seen && !wr_status) |=> state.sync_seen)
    else $error("Sticky sync bit dropped");

  irq_set_a: assert property (
    (|irq_evt) |=> (state.irq_status & $past(irq_evt)) == $past(irq_evt))
    else $error("Interrupt status bit not set");

  irq_on_a: assert property (
    (|(state.irq_status & state.irq_mask)) |=> o_irq)
    else $error("Interrupt not raised");

  irq_off_a: assert property (
    !(|(state.irq_status & state.irq_mask)) |=> !o_irq)
    else $error("Interrupt not lowered");
endmodule : prbs_checker_status_counters

/* prbs_stat_pkg.sv */
package prbs_stat_pkg;
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;

  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_BYTE_COUNT = 10'h11c;
  localparam logic [IDX_W-1:0] IDX_PKT_LOW = 10'h11d;
  localparam logic [IDX_W-1:0] IDX_PKT_HIGH = 10'h11e;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h11f;
  localparam logic [IDX_W-1:0] IDX_ERR_OV = 10'h120;
  localparam logic [IDX_W-1:0] IDX_ERR_PKT_LOW = 10'h121;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 10'h130;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h131;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h132;

  // Counter widths
  localparam int PKT_W = 32;
  localparam int BYTE_W = 16;
  localparam int ERR_W = 8;
  localparam int ERR_OV_W = 8;
  localparam int ERR_PKT_W = 32;

  // Status word fields
  localparam int BIT_SNAPSHOT = 0;
  localparam int BIT_SNAP_CLEAR = 1;
  localparam int BIT_LOCK = 8;
  localparam int BIT_BYTE_OV = 9;
  localparam int BIT_PKT_OV = 10;
  localparam int BIT_GEN_BUSY = 11;
  localparam int BIT_GEN_DONE = 12;
  localparam int BIT_SYNC_SEEN = 13;

  // Control register fields
  localparam int BIT_CONTINUOUS = 0;
  localparam logic RESET_CONTINUOUS = 1'b0;

  // Interrupt status and mask layout
  localparam int IRQ_W = 4;
  localparam int IRQ_PKT_OV = 0;
  localparam int IRQ_BYTE_OV = 1;
  localparam int IRQ_GEN_DONE = 2;
  localparam int IRQ_SYNC = 3;
endpackage : prbs_stat_pkg

/* sat_counter.sv */
`timescale 1ns/1ns
module sat_counter #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_inc,
  input wire logic i_clear,
  input wire logic i_continuous,
  output logic [WIDTH-1:0] o_count,
  output logic o_at_max,
  output logic o_wrap
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } cnt_state_t;

  cnt_state_t state;
  cnt_state_t next_state;

  assign o_count = state.count;
  assign o_at_max = &state.count;
  assign o_wrap = i_inc & o_at_max & i_continuous & ~i_clear;

  // Wraps in continuous mode, holds at full scale in single mode
  always_comb begin
    next_state = state;
    if (i_clear) begin
      next_state.count = '0;
    end else if (i_inc && (!o_at_max || i_continuous)) begin
      next_state.count = WIDTH'(state.count + 1'b1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule : sat_counter

/* testbench.sv */
`timescale 1ns/1ns
module testbench;
  import prbs_stat_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] evt = 4'h0;
  logic locked = 1'b0;
  logic busy = 1'b0;
  logic done = 1'b0;
  logic irq;
  logic [DATA_W-1:0] rd;
  logic slverr;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  // Event bits: 0 packet, 1 errored packet, 2 byte, 3 bit error
  prbs_checker_status_counters u_prbs_checker_status_counters (
    .i_clk_sys(clk),
    .i_resetn(resetn),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_rx_packet(evt[0]),
    .i_rx_packet_errored(evt[1]),
    .i_rx_byte(evt[2]),
    .i_bit_error(evt[3]),
    .i_checker_locked(locked),
    .i_gen_busy(busy),
    .i_gen_done(done),
    .o_irq(irq)
  );

  task automatic check(input string name, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Hang guard, the whole run needs about 66600 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rchk(input string name, input logic [IDX_W-1:0] idx,
                      input logic [DATA_W-1:0] exp);
    apb(1'b0, idx, '0);
    check(name, rd, exp);
  endtask : rchk

  // Holds the selected event inputs high for n edges
  task automatic ev(input logic [3:0] s, input int n);
    @(posedge clk);
    evt <= s;
    repeat (n) @(posedge clk);
    evt <= 4'h0;
  endtask : ev

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rchk("pkt_high", IDX_PKT_HIGH, 32'h0000_0000);
    rchk("status", IDX_STATUS, 32'h0000_0000);
    rchk("err_ov", IDX_ERR_OV, 32'h0000_0000);
    rchk("err_pkt_low", IDX_ERR_PKT_LOW, 32'h0000_0000);
    rchk("pkt_low", IDX_PKT_LOW, 32'h0000_0000);
    apb(1'b0, 10'h100, '0);
    check("unmapped_err", 32'(slverr), 32'h0000_0001);
    wr(IDX_PKT_HIGH, 32'h0000_ffff);
    rchk("pkt_high_ro", IDX_PKT_HIGH, 32'h0000_0000);
    $display("Test reset and access done");

    ev(4'b1111, 2);
    ev(4'b1001, 1);
    wr(IDX_STATUS, 32'h0000_0001);
    rchk("pkt_low", IDX_PKT_LOW, 32'h0000_0003);
    rchk("pkt_high", IDX_PKT_HIGH, 32'h0000_0000);
    rchk("err_pkt_low", IDX_ERR_PKT_LOW, 32'h0000_0002);
    rchk("byte_cnt", IDX_BYTE_COUNT, 32'h0000_0002);
    rchk("status", IDX_STATUS, 32'h0000_0003);
    ev(4'b0001, 4);
    rchk("pkt_low_frozen", IDX_PKT_LOW, 32'h0000_0003);
    wr(IDX_STATUS, 32'h0000_0002);
    rchk("pkt_low_lock", IDX_PKT_LOW, 32'h0000_0007);
    wr(IDX_STATUS, 32'h0000_0001);
    rchk("pkt_low_clr", IDX_PKT_LOW, 32'h0000_0000);
    rchk("status_clr", IDX_STATUS, 32'h0000_0000);
    $display("Test snapshot and clear done");

    @(posedge clk);
    locked <= 1'b1;
    busy <= 1'b1;
    rchk("status_live", IDX_STATUS, 32'h0000_2900);
    wr(IDX_STATUS, 32'h0000_2000);
    rchk("sync_keep", IDX_STATUS, 32'h0000_2900);
    wr(IDX_STATUS, 32'h0000_0000);
    rchk("sync_clr", IDX_STATUS, 32'h0000_0900);
    @(posedge clk);
    busy <= 1'b0;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    rchk("status_done", IDX_STATUS, 32'h0000_1100);
    check("irq_masked", 32'(irq), 32'h0000_0000);
    wr(IDX_IRQ_MASK, 32'h0000_0004);
    repeat (3) @(posedge clk);
    check("irq_on", 32'(irq), 32'h0000_0001);
    rchk("irq_status", IDX_IRQ_STATUS, 32'h0000_000c);
    wr(IDX_IRQ_STATUS, 32'h0000_000f);
    repeat (3) @(posedge clk);
    check("irq_off", 32'(irq), 32'h0000_0000);
    rchk("irq_status_clr", IDX_IRQ_STATUS, 32'h0000_0000);
    $display("Test live bits and interrupt done");

    wr(IDX_STATUS, 32'h0000_0002);
    ev(4'b1000, 300);
    ev(4'b0011, 2);
    wr(IDX_STATUS, 32'h0000_0001);
    rchk("err_sat", IDX_STATUS, 32'h0000_11ff);
    rchk("pkt_halted", IDX_PKT_LOW, 32'h0000_0000);
    rchk("err_ov_single", IDX_ERR_OV, 32'h0000_0000);
    $display("Test single mode done");

    wr(IDX_STATUS, 32'h0000_0002);
    ev(4'b0100, 65535);
    wr(IDX_STATUS, 32'h0000_0001);
    rchk("byte_sat", IDX_BYTE_COUNT, 32'h0000_ffff);
    rchk("byte_ov", IDX_STATUS, 32'h0000_1300);
    rchk("irq_byte_ov", IDX_IRQ_STATUS, 32'h0000_0002);
    wr(IDX_STATUS, 32'h0000_0002);
    rchk("byte_ov_clr", IDX_STATUS, 32'h0000_1100);
    $display("Test byte overflow done");

    wr(IDX_CONTROL, 32'h0000_0001);
    wr(IDX_STATUS, 32'h0000_0002);
    ev(4'b1000, 257);
    ev(4'b0001, 3);
    wr(IDX_STATUS, 32'h0000_0001);
    rchk("err_ov_cont", IDX_ERR_OV, 32'h0000_0001);
    rchk("err_wrap", IDX_STATUS, 32'h0000_1101);
    rchk("pkt_cont", IDX_PKT_LOW, 32'h0000_0003);
    ev(4'b1000, 256);
    rchk("err_ov_frozen", IDX_ERR_OV, 32'h0000_0001);
    $display("Test continuous mode done");
    complete_run();
  end
endmodule : testbench
